// ===== tlf_pkg.sv
// package: register map, reset values and helpers for the thermal limit block
package tlf_pkg;

  localparam int TLF_NCH = 5;

  localparam logic [7:0] TLF_ADDR_EXT1_CRIT = 8'h19;
  localparam logic [7:0] TLF_ADDR_EXT2_CRIT = 8'h1A;
  localparam logic [7:0] TLF_ADDR_FAULT = 8'h1B;
  localparam logic [7:0] TLF_ADDR_STRAP_LIM = 8'h1E;
  localparam logic [7:0] TLF_ADDR_MASK = 8'h1F;
  localparam logic [7:0] TLF_ADDR_INT_CRIT = 8'h20;
  localparam logic [7:0] TLF_ADDR_HYST = 8'h21;
  localparam logic [7:0] TLF_ADDR_EXT3_CRIT = 8'h30;
  localparam logic [7:0] TLF_ADDR_EXT4_CRIT = 8'h38;

  localparam logic [7:0] TLF_CRIT_RESET = 8'h00;
  localparam logic [7:0] TLF_HYST_RESET = 8'h0A;
  localparam logic [7:0] TLF_STRAP_RESET = 8'h00;
  localparam logic [4:0] TLF_MASK_RESET = 5'h00;
  localparam logic [4:0] TLF_FAULT_RESET = 5'h00;

  // fault and mask bit layout: bit 0 internal, bits 1..4 external diodes
  localparam int TLF_MASK_W = 5;
  localparam int TLF_INT_BIT = 0;
  localparam int TLF_EXT1_BIT = 1;

  // release hysteresis of the strapped shutdown trip, in degrees
  localparam logic [7:0] TLF_HW_HYST = 8'h0A;
  // extended range shifts every code by this offset
  localparam logic [7:0] TLF_EXT_RANGE_OFFSET = 8'h40;

  function automatic logic [7:0] tlf_sat_sub(input logic [7:0] a, input logic [7:0] b);
    tlf_sat_sub = (a > b) ? 8'(a - b) : 8'h00;
  endfunction : tlf_sat_sub

  function automatic logic [7:0] tlf_encode(input logic [7:0] deg, input logic ext_range);
    tlf_encode = ext_range ? 8'(deg + TLF_EXT_RANGE_OFFSET) : deg;
  endfunction : tlf_encode

endpackage : tlf_pkg

// ===== tlf_hyst_latch.sv
// module: trip latch that sets above one threshold and releases below another
`timescale 1ns/1ps
module tlf_hyst_latch
  import tlf_pkg::*;
(
  input wire logic core_clk,
  input wire logic reset,
  input wire logic sample,
  input wire logic enable,
  input wire logic [7:0] temp,
  input wire logic [7:0] set_limit,
  input wire logic [7:0] clear_limit,
  output logic active_q
);

  // only evaluated on a finished conversion so a half-updated value never trips it
  always_ff @(posedge core_clk or posedge reset)
  begin
    if (reset)
    begin
      active_q <= 1'b0;
    end
    else if (!enable)
    begin
      active_q <= 1'b0;
    end
    else if (sample)
    begin
      if (temp > set_limit)
      begin
        active_q <= 1'b1;
      end
      else if (temp < clear_limit)
      begin
        active_q <= 1'b0;
      end
    end
  end

endmodule : tlf_hyst_latch

// ===== tlf_fault_flags.sv
// module: sticky diode fault flags that clear when read
`timescale 1ns/1ps
module tlf_fault_flags
  import tlf_pkg::*;
(
  input wire logic core_clk,
  input wire logic reset,
  input wire logic [3:0] fault_in,
  input wire logic clear_read,
  output logic [4:0] flags_q
);

  logic [4:0] set_bits;
  logic [4:0] flags_d;

  always_comb
  begin
    set_bits = {fault_in, 1'b0};
    // a fault arriving in the read cycle survives the clear
    flags_d = (clear_read ? TLF_FAULT_RESET : flags_q) | set_bits;
  end

  always_ff @(posedge core_clk or posedge reset)
  begin
    if (reset)
    begin
      flags_q <= TLF_FAULT_RESET;
    end
    else
    begin
      flags_q <= flags_d;
    end
  end

endmodule : tlf_fault_flags

// ===== tlf_thermal_limit_fault_mask.sv
// module: critical limits, strapped shutdown, diode fault flags and warning mask
//
// Summary of operation
// - read-only strapped shutdown limit at 0x1E, loaded from the strap pins at the first edge after reset
// - strapped limit reported in the temperature format chosen by the range bit
// - shutdown asserts when diode 1 (or internal on single-channel) exceeds strapped limit
// - strapped shutdown holds until temperature drops below limit minus ten degrees
// - four external critical limits at 0x19, 0x1A, 0x30, 0x38, reset zero
// - internal critical limit at 0x20, reset zero
// - shared critical hysteresis at 0x21, resets to 0x0A
// - fault register at 0x1B names the diodes behind the summary fault flag
// - reading the fault register clears all its bits except faults arriving in the read cycle
// - fault bits 1..4 flag external diodes 1..4, one means fault
// - mask register at 0x1F keeps masked channels off the warning output
// - critical output ignores the mask
// - mask bits 1..4 for external diodes, one suppresses, reset zero
// - mask bit 0 suppresses internal limit violations only
// - linked channels hold shutdown until below critical limit minus hysteresis
`timescale 1ns/1ps
module tlf_thermal_limit_fault_mask
  import tlf_pkg::*;
#(
  parameter bit SINGLE_CHANNEL = 1'b0
)
(
  input wire logic core_clk,
  input wire logic reset,
  input wire logic [7:0] reg_addr,
  input wire logic [7:0] reg_wdata,
  input wire logic reg_wr,
  input wire logic reg_rd,
  output logic [7:0] reg_rdata_q,
  input wire logic conv_done,
  input wire logic [7:0] int_temp,
  input wire logic [7:0] ext1_temp,
  input wire logic [7:0] ext2_temp,
  input wire logic [7:0] ext3_temp,
  input wire logic [7:0] ext4_temp,
  input wire logic [3:0] ext_diode_problem,
  input wire logic range_ext,
  input wire logic [4:0] sys_link,
  input wire logic [7:0] strap_limit_deg,
  output logic system_off_out_q,
  output logic warn_out_q,
  output logic crit_out_q,
  output logic fault_summary_q
);

  ////////////////////////////////////////////////////////////////////////////
  // registers

  logic [7:0] ext_crit_limit_q [1:4];
  logic [7:0] int_crit_limit_q;
  logic [7:0] crit_hysteresis_value_q;
  logic [4:0] mask_q;
  logic [7:0] strap_raw_q;
  logic strap_taken_q;
  logic [7:0] strapped_off_limit_q;
  logic [4:0] fault_flags;
  logic fault_rd;

  logic wr_ext1;
  logic wr_ext2;
  logic wr_ext3;
  logic wr_ext4;
  assign wr_ext1 = reg_wr && (reg_addr == TLF_ADDR_EXT1_CRIT);
  assign wr_ext2 = reg_wr && (reg_addr == TLF_ADDR_EXT2_CRIT);
  assign wr_ext3 = reg_wr && (reg_addr == TLF_ADDR_EXT3_CRIT);
  assign wr_ext4 = reg_wr && (reg_addr == TLF_ADDR_EXT4_CRIT);

  always_ff @(posedge core_clk or posedge reset)
  begin
    if (reset)
    begin
      ext_crit_limit_q[1] <= TLF_CRIT_RESET;
      ext_crit_limit_q[2] <= TLF_CRIT_RESET;
      ext_crit_limit_q[3] <= TLF_CRIT_RESET;
      ext_crit_limit_q[4] <= TLF_CRIT_RESET;
    end
    else
    begin
      if (wr_ext1) ext_crit_limit_q[1] <= reg_wdata;
      if (wr_ext2) ext_crit_limit_q[2] <= reg_wdata;
      if (wr_ext3) ext_crit_limit_q[3] <= reg_wdata;
      if (wr_ext4) ext_crit_limit_q[4] <= reg_wdata;
    end
  end

  always_ff @(posedge core_clk or posedge reset)
  begin
    if (reset)
    begin
      int_crit_limit_q <= TLF_CRIT_RESET;
      crit_hysteresis_value_q <= TLF_HYST_RESET;
      mask_q <= TLF_MASK_RESET;
    end
    else if (reg_wr)
    begin
      case (reg_addr)
        TLF_ADDR_INT_CRIT: int_crit_limit_q <= reg_wdata;
        TLF_ADDR_HYST: crit_hysteresis_value_q <= reg_wdata;
        TLF_ADDR_MASK: mask_q <= reg_wdata[TLF_MASK_W-1:0];
        default: ;
      endcase
    end
  end

  // the strap is caught once after reset release; writes to it are ignored
  always_ff @(posedge core_clk or posedge reset)
  begin
    if (reset)
    begin
      strap_raw_q <= TLF_STRAP_RESET;
      strap_taken_q <= 1'b0;
    end
    else if (!strap_taken_q)
    begin
      strap_raw_q <= strap_limit_deg;
      strap_taken_q <= 1'b1;
    end
  end

  // re-encoded every cycle so a range change is followed at the next edge
  always_ff @(posedge core_clk or posedge reset)
  begin
    if (reset)
    begin
      strapped_off_limit_q <= TLF_STRAP_RESET;
    end
    else
    begin
      // until the strap is caught the pins feed the encoder directly, so the limit is
      // already valid at the edge that enables the shutdown latch
      strapped_off_limit_q <= tlf_encode(strap_taken_q ? strap_raw_q : strap_limit_deg,
        range_ext);
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // register read and fault flags

  assign fault_rd = reg_rd && (reg_addr == TLF_ADDR_FAULT);

  tlf_fault_flags u_fault_flags (
    .core_clk(core_clk),
    .reset(reset),
    .fault_in(ext_diode_problem),
    .clear_read(fault_rd),
    .flags_q(fault_flags)
  );

  always_ff @(posedge core_clk or posedge reset)
  begin
    if (reset)
    begin
      reg_rdata_q <= 8'h00;
    end
    else if (reg_rd)
    begin
      case (reg_addr)
        TLF_ADDR_EXT1_CRIT: reg_rdata_q <= ext_crit_limit_q[1];
        TLF_ADDR_EXT2_CRIT: reg_rdata_q <= ext_crit_limit_q[2];
        TLF_ADDR_EXT3_CRIT: reg_rdata_q <= ext_crit_limit_q[3];
        TLF_ADDR_EXT4_CRIT: reg_rdata_q <= ext_crit_limit_q[4];
        TLF_ADDR_FAULT: reg_rdata_q <= {3'b000, fault_flags};
        TLF_ADDR_STRAP_LIM: reg_rdata_q <= strapped_off_limit_q;
        TLF_ADDR_MASK: reg_rdata_q <= {3'b000, mask_q};
        TLF_ADDR_INT_CRIT: reg_rdata_q <= int_crit_limit_q;
        TLF_ADDR_HYST: reg_rdata_q <= crit_hysteresis_value_q;
        default: reg_rdata_q <= 8'h00;
      endcase
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // per-channel critical and linked shutdown latches

  logic [7:0] ch_temp [0:TLF_NCH-1];
  logic [7:0] ch_limit [0:TLF_NCH-1];
  logic [TLF_NCH-1:0] crit_state;
  logic [TLF_NCH-1:0] link_state;

  always_comb
  begin
    ch_temp[0] = int_temp;
    ch_temp[1] = ext1_temp;
    ch_temp[2] = ext2_temp;
    ch_temp[3] = ext3_temp;
    ch_temp[4] = ext4_temp;
    ch_limit[0] = int_crit_limit_q;
    ch_limit[1] = ext_crit_limit_q[1];
    ch_limit[2] = ext_crit_limit_q[2];
    ch_limit[3] = ext_crit_limit_q[3];
    ch_limit[4] = ext_crit_limit_q[4];
  end

  for (genvar g = 0; g < TLF_NCH; g++)
  begin : g_ch
    tlf_hyst_latch u_crit (
      .core_clk(core_clk),
      .reset(reset),
      .sample(conv_done),
      .enable(1'b1),
      .temp(ch_temp[g]),
      .set_limit(ch_limit[g]),
      .clear_limit(tlf_sat_sub(ch_limit[g], crit_hysteresis_value_q)),
      .active_q(crit_state[g])
    );
    tlf_hyst_latch u_link (
      .core_clk(core_clk),
      .reset(reset),
      .sample(conv_done),
      .enable(sys_link[g] && strap_taken_q),
      .temp(ch_temp[g]),
      .set_limit(strapped_off_limit_q),
      .clear_limit(tlf_sat_sub(ch_limit[g], crit_hysteresis_value_q)),
      .active_q(link_state[g])
    );
  end

  logic [7:0] hw_temp;
  logic hw_state;
  assign hw_temp = SINGLE_CHANNEL ? int_temp : ext1_temp;

  tlf_hyst_latch u_hw (
    .core_clk(core_clk),
    .reset(reset),
    .sample(conv_done),
    .enable(strap_taken_q),
    .temp(hw_temp),
    .set_limit(strapped_off_limit_q),
    .clear_limit(tlf_sat_sub(strapped_off_limit_q, TLF_HW_HYST)),
    .active_q(hw_state)
  );

  ////////////////////////////////////////////////////////////////////////////
  // outputs

  logic [TLF_NCH-1:0] warn_src;
  always_comb
  begin
    // the internal channel has no diode fault, so only its limit counts
    warn_src = crit_state | fault_flags;
    warn_src = warn_src & ~mask_q;
  end

  always_ff @(posedge core_clk or posedge reset)
  begin
    if (reset)
    begin
      system_off_out_q <= 1'b0;
      warn_out_q <= 1'b0;
      crit_out_q <= 1'b0;
      fault_summary_q <= 1'b0;
    end
    else
    begin
      system_off_out_q <= hw_state | (|link_state);
      warn_out_q <= |warn_src;
      crit_out_q <= |crit_state;
      fault_summary_q <= |fault_flags;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // checks

  sequence s_hw_trip;
    conv_done && strap_taken_q && (hw_temp > strapped_off_limit_q);
  endsequence

  sequence s_all_masked;
    (mask_q == 5'h1F) [*2];
  endsequence

  a_strap_readback: assert property (@(posedge core_clk) disable iff (reset)
    reg_rd && (reg_addr == TLF_ADDR_STRAP_LIM) |=> reg_rdata_q == $past(strapped_off_limit_q))
    else $error("strapped limit read mismatch");

  a_hyst_write: assert property (@(posedge core_clk) disable iff (reset)
    reg_wr && (reg_addr == TLF_ADDR_HYST) |=> crit_hysteresis_value_q == $past(reg_wdata))
    else $error("hysteresis write lost");

  a_fault_read_clear: assert property (@(posedge core_clk) disable iff (reset)
    fault_rd && (ext_diode_problem == 4'h0) |=> fault_flags == 5'h00 ##1 !fault_summary_q)
    else $error("fault flags not cleared by read");

  a_fault_set_wins: assert property (@(posedge core_clk) disable iff (reset)
    ext_diode_problem[0] |=> fault_flags[TLF_EXT1_BIT] && !fault_flags[TLF_INT_BIT])
    else $error("diode 1 fault not flagged");

  a_warn_masked_off: assert property (@(posedge core_clk) disable iff (reset)
    s_all_masked |=> !warn_out_q)
    else $error("warning with all channels masked");

  a_crit_unmasked: assert property (@(posedge core_clk) disable iff (reset)
    crit_state[1] |=> crit_out_q)
    else $error("critical output follows mask");

  a_hw_shutdown_trip: assert property (@(posedge core_clk) disable iff (reset)
    s_hw_trip |-> ##1 hw_state ##1 system_off_out_q)
    else $error("shutdown not asserted over strapped limit");

  a_hw_shutdown_hold: assert property (@(posedge core_clk) disable iff (reset)
    hw_state && !(conv_done && (hw_temp < tlf_sat_sub(strapped_off_limit_q, TLF_HW_HYST)))
    |=> hw_state)
    else $error("shutdown released above limit minus ten");

  a_crit_compare: assert property (@(posedge core_clk) disable iff (reset)
    conv_done && (ext2_temp > ext_crit_limit_q[2]) |=> crit_state[2] ##1 crit_out_q)
    else $error("critical compare missed");

endmodule : tlf_thermal_limit_fault_mask

// ===== tlf_host_model.sv
// host model: issues register writes and reads on the block's register port
`timescale 1ns/1ps
module tlf_host_model
(
  input wire logic core_clk,
  output logic [7:0] reg_addr,
  output logic [7:0] reg_wdata,
  output logic reg_wr,
  output logic reg_rd,
  input wire logic [7:0] reg_rdata_q
);
  initial
  begin
    reg_addr = 8'h00;
    reg_wdata = 8'h00;
    reg_wr = 1'b0;
    reg_rd = 1'b0;
  end
  //////////////////////////////////////////////////
  // callers enter just after a rising edge; each strobe spans one edge and one idle
  // edge follows, so a following call never re-drives a signal in the same step
  task automatic wr_reg(input logic [7:0] a, input logic [7:0] d);
    reg_addr = a;
    reg_wdata = d;
    reg_wr = 1'b1;
    @(posedge core_clk);
    #1 reg_wr = 1'b0;
    // idle bus shows the inverse so a stale value never matches by luck
    reg_addr = ~a;
    reg_wdata = ~d;
    @(posedge core_clk);
    #1;
  endtask : wr_reg
  task automatic rd_reg(input logic [7:0] a, output logic [7:0] d);
    reg_addr = a;
    reg_rd = 1'b1;
    @(posedge core_clk);
    #1 reg_rd = 1'b0;
    reg_addr = ~a;
    d = reg_rdata_q;
    @(posedge core_clk);
    #1;
  endtask : rd_reg
endmodule : tlf_host_model

// ===== tb.sv
// testbench: register map, fault flags, warning mask and shutdown trips
`timescale 1ns/1ps
module tb;
  import tlf_pkg::*;
  logic core_clk = 1'b0;
  logic reset = 1'b1;
  logic conv_done = 1'b0;
  logic range_ext = 1'b0;
  logic lat = 1'b0;
  logic [7:0] int_temp = 8'h00, ext1_temp = 8'h00, ext2_temp = 8'h00;
  logic [7:0] ext3_temp = 8'h00, ext4_temp = 8'h00;
  logic [7:0] strap_limit_deg = 8'h50;
  logic [3:0] ext_diode_problem = 4'h0;
  logic [4:0] sys_link = 5'h00;
  logic [15:0] lfsr_q = 16'hfe7f;
  logic [7:0] reg_addr, reg_wdata, reg_rdata_q;
  logic reg_wr, reg_rd, system_off_out_q, warn_out_q, crit_out_q, fault_summary_q;
  int fail_count = 0;
  int checked = 0;
  int cycles = 0;
  logic [7:0] map_a [8] = '{8'h19, 8'h1a, 8'h1b, 8'h1f, 8'h20, 8'h21, 8'h30, 8'h38};
  logic [7:0] map_r [8] = '{8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'h0a, 8'h00, 8'h00};

  tlf_thermal_limit_fault_mask #(.SINGLE_CHANNEL(1'b0)) u_tlf_thermal_limit_fault_mask (
    .core_clk(core_clk), .reset(reset), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
    .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata_q(reg_rdata_q), .conv_done(conv_done),
    .int_temp(int_temp), .ext1_temp(ext1_temp), .ext2_temp(ext2_temp),
    .ext3_temp(ext3_temp), .ext4_temp(ext4_temp), .ext_diode_problem(ext_diode_problem),
    .range_ext(range_ext), .sys_link(sys_link), .strap_limit_deg(strap_limit_deg),
    .system_off_out_q(system_off_out_q), .warn_out_q(warn_out_q),
    .crit_out_q(crit_out_q), .fault_summary_q(fault_summary_q));
  tlf_host_model u_tlf_host_model (
    .core_clk(core_clk), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
    .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata_q(reg_rdata_q));

  always #50 core_clk = ~core_clk;
  //////////////////////////////////////////////////
  function automatic logic [15:0] lfsr(input logic [15:0] s);
    return {s[14:0], s[15] ^ s[13] ^ s[12] ^ s[10]};
  endfunction : lfsr
  function automatic logic [7:0] enc(input logic [7:0] d, input logic r);
    return r ? d + 8'h40 : d;
  endfunction : enc
  function automatic logic [7:0] sub0(input logic [7:0] a, input logic [7:0] b);
    return (a > b) ? a - b : 8'h00;
  endfunction : sub0
  // trip latch: set strictly above s, release strictly below k
  function automatic logic nxt(input logic c, input logic [7:0] t, input logic [7:0] s,
                               input logic [7:0] k);
    return (t > s) ? 1'b1 : ((t < k) ? 1'b0 : c);
  endfunction : nxt
  //////////////////////////////////////////////////
  task automatic draw(output logic [7:0] v);
    lfsr_q = lfsr(lfsr_q);
    v = lfsr_q[7:0];
  endtask : draw
  task automatic check(input logic [7:0] seen, input logic [7:0] exp);
    checked++;
    if (seen !== exp)
    begin
      fail_count++;
      $display("BAD t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask : check
  task automatic complete_run();
    $display("counts: checked=%0d fail_count=%0d", checked, fail_count);
    if (fail_count == 0 && checked > 0)
      $display("DONE - PASS");
    else
      $display("DONE - FAIL");
    $finish;
  endtask : complete_run
  task automatic tick(input int n);
    repeat (n) @(posedge core_clk);
    #1;
  endtask : tick
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    u_tlf_host_model.wr_reg(a, d);
  endtask : wr
  task automatic rc(input logic [7:0] a, input logic [7:0] e);
    logic [7:0] d;
    u_tlf_host_model.rd_reg(a, d);
    check(d, e);
  endtask : rc
  // outputs settle one edge after the conversion edge
  task automatic conv(input logic [7:0] ti, input logic [7:0] t1, input logic [7:0] t2);
    int_temp = ti;
    ext1_temp = t1;
    ext2_temp = t2;
    conv_done = 1'b1;
    @(posedge core_clk);
    #1 conv_done = 1'b0;
    tick(2);
  endtask : conv
  task automatic trips(input logic [7:0] clr);
    logic [7:0] v;
    logic [7:0] lim;
    lim = enc(strap_limit_deg, 1'b0);
    for (int k = 0; k < 10; k++)
    begin
      draw(v);
      case (k)
        0: v = lim;
        1: v = lim + 8'h01;
        2: v = clr;
        3: v = clr - 8'h01;
        default: v = clr - 8'h04 + {2'b00, v[5:0]};
      endcase
      lat = nxt(lat, v, lim, clr);
      if (sys_link[2])
        conv(8'h00, 8'h00, v);
      else
        conv(8'h00, v, 8'h00);
      check(system_off_out_q, lat);
    end
  endtask : trips
  //////////////////////////////////////////////////
  always @(posedge core_clk)
  begin
    cycles++;
    if (cycles == 3000)
    begin
      fail_count++;
      complete_run();
    end
  end

  initial
  begin
    logic [7:0] v;
    logic [3:0] f;
    tick(2);
    reset = 1'b0;
    tick(2);
    foreach (map_a[i])
      rc(map_a[i], map_r[i]);
    rc(TLF_ADDR_STRAP_LIM, enc(strap_limit_deg, 1'b0));
    wr(TLF_ADDR_STRAP_LIM, 8'hff);
    range_ext = 1'b1;
    tick(2);
    rc(TLF_ADDR_STRAP_LIM, enc(strap_limit_deg, 1'b1));
    range_ext = 1'b0;
    $display("test reset values done");
    for (int k = 0; k < 3; k++)
    begin
      draw(v);
      f = (v[3:0] == 4'h0) ? 4'h8 : v[3:0];
      ext_diode_problem = f;
      @(posedge core_clk);
      #1 ext_diode_problem = 4'h0;
      tick(2);
      check(fault_summary_q, 8'h01);
      check(warn_out_q, 8'h01);
      wr(TLF_ADDR_MASK, {3'b000, f, 1'b0});
      tick(2);
      check(warn_out_q, 8'h00);
      rc(TLF_ADDR_FAULT, {3'b000, f, 1'b0});
      rc(TLF_ADDR_FAULT, 8'h00);
      wr(TLF_ADDR_MASK, 8'h00);
    end
    $display("test fault flags done");
    foreach (map_a[i])
    begin
      draw(v);
      wr(map_a[i], v);
      rc(map_a[i], (i == 2) ? 8'h00 : (i == 3) ? {3'b000, v[4:0]} : v);
    end
    wr(8'h00, 8'h5a);
    rc(8'h00, 8'h00);
    $display("test register access done");
    wr(TLF_ADDR_INT_CRIT, 8'h30);
    wr(TLF_ADDR_HYST, 8'h0a);
    wr(TLF_ADDR_MASK, 8'h1f);
    conv(8'h31, 8'h00, 8'h00);
    check(crit_out_q, 8'h01);
    check(warn_out_q, 8'h00);
    conv(8'h26, 8'h00, 8'h00);
    check(crit_out_q, 8'h01);
    wr(TLF_ADDR_MASK, 8'h1e);
    tick(2);
    check(warn_out_q, 8'h01);
    conv(8'h25, 8'h00, 8'h00);
    check(crit_out_q, 8'h00);
    $display("test critical limit done");
    trips(sub0(enc(strap_limit_deg, 1'b0), 8'h0a));
    conv(8'h00, 8'h00, 8'h00);
    lat = 1'b0;
    wr(TLF_ADDR_EXT2_CRIT, 8'h40);
    sys_link = 5'h04;
    trips(sub0(8'h40, 8'h0a));
    $display("test shutdown trips done");
    // known limits first, so no channel is left stuck by a random limit below the hysteresis
    wr(TLF_ADDR_EXT1_CRIT, 8'h60);
    wr(TLF_ADDR_EXT4_CRIT, 8'h20);
    wr(TLF_ADDR_MASK, 8'h10);
    ext4_temp = 8'h21;
    conv(8'h00, 8'h00, 8'h00);
    check(crit_out_q, 8'h01);
    check(warn_out_q, 8'h00);
    wr(TLF_ADDR_MASK, 8'h00);
    tick(2);
    check(warn_out_q, 8'h01);
    ext4_temp = 8'h00;
    conv(8'h00, 8'h00, 8'h00);
    check(crit_out_q, 8'h00);
    $display("test masked channel done");
    complete_run();
  end
endmodule : tb
